// ==== spcp_check.sv ====
// Registered validation of a requested operation, yields an error code
`timescale 1ns/1ps
`default_nettype none
module spcp_check
  import spcp_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic [7:0] i_cmd,
  input  wire logic [7:0] i_sel,
  input  wire spcp_cfg_t  i_val,
  output var  logic [5:0] o_err
);

  function automatic logic out_rng(input logic [7:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
    return (v < lo) || (v > hi);
  endfunction

  logic [2:0] ops;
  logic [5:0] err_nxt;

  assign ops = i_cmd[CMD_WR_BIT:CMD_CLR_BIT];

  always_comb begin
    err_nxt = ERR_NONE;
    if ((ops & (ops - 3'h1)) != 3'h0) begin
      err_nxt = ERR_COMBO;                                    // see RULE_12
    end else if (i_cmd[3:0] != PORT_FIRST && i_cmd[3:0] != PORT_SECOND) begin
      err_nxt = ERR_PORT;                                     // see RULE_09
    end else if (ops[1]) begin
      err_nxt = ERR_NONE;                                     // see RULE_13
    end else if (i_sel[7:3] != 5'h00 || i_sel[2:0] == 3'h0) begin
      err_nxt = ERR_SEL;                                      // see RULE_11
    end else if (ops[0]) begin
      err_nxt = ERR_NONE;                                     // see RULE_04
    end else if (i_sel[0] && out_rng(i_val.station, STATION_MIN, STATION_MAX)) begin
      err_nxt = ERR_STATION;                                  // see RULE_01
    end else if (i_sel[1] && out_rng(i_val.baud, 8'h00, BAUD_MAX)) begin
      err_nxt = ERR_BAUD;                                     // see RULE_02
    end else if (i_sel[2] && out_rng(i_val.parity, 8'h00, PARITY_MAX)) begin
      err_nxt = ERR_PARITY;                                   // see RULE_03
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_err <= ERR_NONE;
    end else begin
      o_err <= err_nxt;                                       // see RULE_18
    end
  end

endmodule
`default_nettype wire

// ==== spcp_ctrl.sv ====
// Serial port parameter control: register slave, operation sequencer, active configuration
//
// Behaviour
// (RULE_01) Station number for a write must be 1 to 31, else value error.
// (RULE_02) Baud codes 0..5 mean 2400, 4800, 9600, 19200, 38400, 1200.
// (RULE_03) Parity codes 0..2 mean none, odd, even.
// (RULE_04) Value registers feed writes, receive read results, are ignored by clears.
// (RULE_05) Command bit 7 starts a write; hardware clears it when done.
// (RULE_06) Command bit 6 starts a read; hardware clears it when done.
// (RULE_07) Command bit 5 starts a clear; hardware clears it when done.
// (RULE_08) Software writes zero to command bit 4.
// (RULE_09) Command low nibble selects port 1 or 2; other values fail the operation.
// (RULE_10) Software writes zeros to select bits 7 to 3.
// (RULE_11) Select bits 2,1,0 pick parity, baud, station for write or clear.
// (RULE_12) More than one start bit set fails the operation.
// (RULE_13) A read ignores select and returns all three values at once.
// (RULE_14) A clear reverts chosen values to the hardware configuration.
// (RULE_15) Every finished operation sets status bit 7.
// (RULE_16) Status bit 6 is 1 on success, 0 on failure.
// (RULE_17) A failure places its error code in status bits 5 to 0.
// (RULE_18) Validation codes 1 to 6: combo, port, select, station, baud, parity.
// (RULE_19) First port: 10/12/14 store read failure, 11/13/15 never set.
// (RULE_20) Second port: 20/22/24 store read failure, 21/23/25 never set.
// (RULE_21) Failure to store parameters permanently reports code 61.
// (RULE_22) Software starts a new operation only after status bit 7 reads 1.
// (RULE_23) Starting an operation clears the done and success status bits.
`timescale 1ns/1ps
`default_nettype none
module spcp_ctrl
  import spcp_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_resetn,
  input  wire spcp_avs_req_t     i_avs,
  output var  logic              o_avs_waitrequest,
  output var  logic [AVS_DW-1:0] o_avs_readdata,
  input  wire spcp_cfg_t         i_hw_cfg1,
  input  wire spcp_cfg_t         i_hw_cfg2,
  input  wire logic              i_nv_rd_err,
  input  wire logic              i_nv_wr_err,
  output var  spcp_cfg_t         o_first_serial_port_cfg,
  output var  spcp_cfg_t         o_second_serial_port_cfg,
  output var  logic              o_busy
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [7:0] get_field(input spcp_cfg_t c, input logic [1:0] idx);
    logic [7:0] v;
    v = c.station;
    unique case (idx)
      2'h1:    v = c.baud;
      2'h2:    v = c.parity;
      default: v = c.station;
    endcase
    return v;
  endfunction

  function automatic spcp_cfg_t set_field(input spcp_cfg_t c, input logic [1:0] idx,
                                          input logic [7:0] v);
    spcp_cfg_t r;
    r = c;
    unique case (idx)
      2'h1:    r.baud = v;
      2'h2:    r.parity = v;
      default: r.station = v;
    endcase
    return r;
  endfunction

  function automatic logic [5:0] store_code(input logic p2, input logic [1:0] idx,
                                            input logic unset);
    logic [5:0] base;
    base = p2 ? ERR_P2_BASE : ERR_P1_BASE;
    return base + {3'h0, idx, 1'b0} + {5'h00, unset};
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************
  spcp_state_t         state_r;
  logic [1:0]          idx_r;
  logic [7:0]          cmd_r;
  logic [7:0]          sel_r;
  logic [7:0]          stat_r;
  spcp_cfg_t           val_r;
  logic [5:0]          chk_err;
  logic [STORE_DW-1:0] mem_rd;
  logic [STORE_DW-1:0] mem_wd;
  logic                mem_we;
  logic                bus_req;
  logic                wr_acc;
  logic                idle;
  logic                start_w;
  logic                op_rd;
  logic                op_clr;
  logic                second_serial_port;
  logic                fin_w;
  logic                fin_ok;
  logic [5:0]          fin_code;
  logic [7:0]          rd_byte;
  logic [7:0]          new_val;

  assign bus_req = i_avs.read | i_avs.write;
  assign wr_acc  = i_avs.write && !o_avs_waitrequest;
  assign idle    = (state_r == ST_IDLE);
  assign op_rd   = cmd_r[CMD_RD_BIT];
  assign op_clr  = cmd_r[CMD_CLR_BIT];
  assign second_serial_port   = (cmd_r[3:0] == PORT_SECOND);
  assign start_w = wr_acc && idle && (i_avs.address == OFS_CMD)
                   && (i_avs.writedata[CMD_WR_BIT:CMD_CLR_BIT] != 3'h0);

  // ************************************************************
  // Avalon-MM slave: one wait state, data registered
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (i_avs.address)
      OFS_CMD:     rd_byte = cmd_r;
      OFS_SEL:     rd_byte = sel_r;
      OFS_STAT:    rd_byte = stat_r;
      OFS_STATION: rd_byte = val_r.station;
      OFS_BAUD:    rd_byte = val_r.baud;
      OFS_PARITY:  rd_byte = val_r.parity;
      default:     rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_avs_readdata <= '0;
    end else if (i_avs.read && o_avs_waitrequest) begin
      o_avs_readdata <= {24'h000000, rd_byte};
    end
  end

  // ************************************************************
  // Command and select registers
  // ************************************************************
  // Writes are ignored while busy, so the hardware clear of a start bit
  // can never collide with software touching the command register.
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      cmd_r <= CMD_RST;
    end else if (fin_w) begin
      cmd_r[CMD_WR_BIT:CMD_CLR_BIT] <= 3'h0;                  // see RULE_05 RULE_06 RULE_07
    end else if (wr_acc && idle && i_avs.address == OFS_CMD) begin
      cmd_r <= i_avs.writedata[7:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      sel_r <= SEL_RST;
    end else if (wr_acc && idle && i_avs.address == OFS_SEL) begin
      sel_r <= i_avs.writedata[7:0];
    end
  end

  // ************************************************************
  // Value registers
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      val_r <= '0;
    end else if (state_r == ST_RDDATA && !i_nv_rd_err && mem_rd[8]) begin
      val_r <= set_field(val_r, idx_r, mem_rd[7:0]);          // see RULE_04 RULE_13
    end else if (wr_acc && idle) begin
      unique case (i_avs.address)
        OFS_STATION: val_r.station <= i_avs.writedata[7:0];
        OFS_BAUD:    val_r.baud <= i_avs.writedata[7:0];
        OFS_PARITY:  val_r.parity <= i_avs.writedata[7:0];
        default:     val_r <= val_r;
      endcase
    end
  end

  // ************************************************************
  // Validation and store
  // ************************************************************
  spcp_check u_check (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_cmd    (cmd_r),
    .i_sel    (sel_r),
    .i_val    (val_r),
    .o_err    (chk_err)
  );

  // A clear writes an invalid entry so later reads see "never set"
  assign mem_we = (state_r == ST_WRITE) && sel_r[idx_r];      // see RULE_11
  assign mem_wd = op_clr ? {1'b0, 8'h00} : {1'b1, get_field(val_r, idx_r)};

  spcp_store u_store (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_we     (mem_we),
    .i_addr   ({second_serial_port, idx_r}),
    .i_wdata  (mem_wd),
    .o_rdata  (mem_rd)
  );

  // ************************************************************
  // Operation outcome
  // ************************************************************
  always_comb begin
    fin_w    = 1'b0;
    fin_ok   = 1'b0;
    fin_code = ERR_NONE;
    unique case (state_r)
      ST_DECIDE: begin
        if (chk_err != ERR_NONE) begin
          fin_w    = 1'b1;
          fin_code = chk_err;                                 // see RULE_18
        end else if (!op_rd && i_nv_wr_err) begin
          fin_w    = 1'b1;
          fin_code = ERR_NV_WRITE;                            // see RULE_21
        end
      end
      ST_WRITE: begin
        fin_w  = (idx_r == 2'h2);
        fin_ok = fin_w;
      end
      ST_RDDATA: begin
        if (i_nv_rd_err) begin
          fin_w    = 1'b1;
          fin_code = store_code(second_serial_port, idx_r, 1'b0);          // see RULE_19 RULE_20
        end else if (!mem_rd[8]) begin
          fin_w    = 1'b1;
          fin_code = store_code(second_serial_port, idx_r, 1'b1);          // see RULE_19 RULE_20
        end else begin
          fin_w  = (idx_r == 2'h2);
          fin_ok = fin_w;
        end
      end
      default: begin
        fin_w = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state_r <= ST_IDLE;
      idx_r   <= 2'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_w) begin
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          state_r <= ST_DECIDE;
        end
        ST_DECIDE: begin
          idx_r <= 2'h0;
          if (fin_w) begin
            state_r <= ST_IDLE;
          end else if (op_rd) begin
            state_r <= ST_RDADDR;
          end else begin
            state_r <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          idx_r <= idx_r + 2'h1;
          if (fin_w) begin
            state_r <= ST_IDLE;
          end
        end
        ST_RDADDR: begin
          state_r <= ST_RDDATA;
        end
        ST_RDDATA: begin
          idx_r <= idx_r + 2'h1;
          state_r <= fin_w ? ST_IDLE : ST_RDADDR;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= start_w || (!idle && !fin_w);
    end
  end

  // ************************************************************
  // Status register
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      stat_r <= STAT_RST;
    end else if (start_w) begin
      stat_r <= STAT_RST;                                     // see RULE_23
    end else if (fin_w) begin
      stat_r <= {1'b1, fin_ok, fin_code};                     // see RULE_15 RULE_16 RULE_17
    end
  end

  // ************************************************************
  // Active port configuration
  // ************************************************************
  // Taken from the hardware configuration at reset; dynamic values are
  // not reloaded from the store at power-up.
  assign new_val = op_clr ? get_field(second_serial_port ? i_hw_cfg2 : i_hw_cfg1, idx_r)
                          : get_field(val_r, idx_r);          // see RULE_14

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_first_serial_port_cfg <= i_hw_cfg1;
      o_second_serial_port_cfg <= i_hw_cfg2;
    end else if (mem_we && !second_serial_port) begin
      o_first_serial_port_cfg <= set_field(o_first_serial_port_cfg, idx_r, new_val);
    end else if (mem_we && second_serial_port) begin
      o_second_serial_port_cfg <= set_field(o_second_serial_port_cfg, idx_r, new_val);
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  property p_start_clears;
    start_w |=> !stat_r[STAT_DONE_BIT] && !stat_r[STAT_OK_BIT];
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("status not cleared"); // see RULE_23

  property p_finish_bound;
    start_w |=> o_busy ##[1:9] (!o_busy && stat_r[STAT_DONE_BIT]);
  endproperty
  a_finish_bound: assert property (p_finish_bound) else $error("no completion"); // see RULE_15

  property p_self_clear;
    $fell(o_busy) |-> cmd_r[CMD_WR_BIT:CMD_CLR_BIT] == 3'h0;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("start bit kept"); // see RULE_05

  property p_combo;
    state_r == ST_DECIDE && chk_err == ERR_COMBO |=> stat_r == {2'b10, ERR_COMBO};
  endproperty
  a_combo: assert property (p_combo) else $error("combo error lost"); // see RULE_12

  property p_ok_no_code;
    stat_r[STAT_DONE_BIT] && stat_r[STAT_OK_BIT] |-> stat_r[5:0] == ERR_NONE;
  endproperty
  a_ok_no_code: assert property (p_ok_no_code) else $error("code on success"); // see RULE_16

  property p_fail_code;
    stat_r[STAT_DONE_BIT] && !stat_r[STAT_OK_BIT] |-> stat_r[5:0] != ERR_NONE;
  endproperty
  a_fail_code: assert property (p_fail_code) else $error("failure without code"); // see RULE_17

  property p_nv_write;
    state_r == ST_DECIDE && chk_err == ERR_NONE && !op_rd && i_nv_wr_err
      |=> stat_r == {2'b10, ERR_NV_WRITE} && idle;
  endproperty
  a_nv_write: assert property (p_nv_write) else $error("store failure not 61"); // see RULE_21

  property p_unset_p1;
    state_r == ST_RDDATA && !second_serial_port && !i_nv_rd_err && !mem_rd[8] && idx_r == 2'h1
      |=> stat_r[5:0] == 6'h0D;
  endproperty
  a_unset_p1: assert property (p_unset_p1) else $error("wrong unset code"); // see RULE_19

  property p_station_range;
    state_r == ST_CHECK && cmd_r[CMD_WR_BIT] && cmd_r[3:0] == PORT_FIRST
      && sel_r == 8'h01 && val_r.station == 8'h00 |=> ##1 stat_r[5:0] == ERR_STATION;
  endproperty
  a_station_range: assert property (p_station_range) else $error("station 0 accepted"); // see RULE_01

  property p_write_apply;
    state_r == ST_WRITE && !op_clr && mem_we && !second_serial_port && idx_r == 2'h0
      |=> o_first_serial_port_cfg.station == $past(val_r.station);
  endproperty
  a_write_apply: assert property (p_write_apply) else $error("station not applied"); // see RULE_04

endmodule
`default_nettype wire

// ==== spcp_pkg.sv ====
// Shared constants and types of the serial port parameter control block
package spcp_pkg;

  // ************************************************************
  // Register map (byte addresses on the Avalon-MM slave)
  // ************************************************************
  localparam int unsigned AVS_AW          = 5;
  localparam int unsigned AVS_DW          = 32;
  localparam logic [4:0]  OFS_CMD         = 5'h00;
  localparam logic [4:0]  OFS_SEL         = 5'h04;
  localparam logic [4:0]  OFS_STAT        = 5'h08;
  localparam logic [4:0]  OFS_STATION     = 5'h0C;
  localparam logic [4:0]  OFS_BAUD        = 5'h10;
  localparam logic [4:0]  OFS_PARITY      = 5'h14;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int unsigned CMD_WR_BIT      = 7;
  localparam int unsigned CMD_RD_BIT      = 6;
  localparam int unsigned CMD_CLR_BIT     = 5;
  localparam int unsigned STAT_DONE_BIT   = 7;
  localparam int unsigned STAT_OK_BIT     = 6;
  localparam logic [7:0]  CMD_RST         = 8'h00;
  localparam logic [7:0]  SEL_RST         = 8'h00;
  localparam logic [7:0]  STAT_RST        = 8'h00;
  localparam logic [3:0]  PORT_FIRST      = 4'h1;
  localparam logic [3:0]  PORT_SECOND     = 4'h2;

  // ************************************************************
  // Legal value ranges
  // ************************************************************
  localparam logic [7:0]  STATION_MIN     = 8'h01;
  localparam logic [7:0]  STATION_MAX     = 8'h1F;
  // Baud codes: 0=2400 1=4800 2=9600 3=19200 4=38400 5=1200
  localparam logic [7:0]  BAUD_MAX        = 8'h05;
  // Parity codes: 0=none 1=odd 2=even
  localparam logic [7:0]  PARITY_MAX      = 8'h02;

  // ************************************************************
  // Error codes
  // ************************************************************
  localparam logic [5:0]  ERR_NONE        = 6'h00;
  localparam logic [5:0]  ERR_COMBO       = 6'h01;
  localparam logic [5:0]  ERR_PORT        = 6'h02;
  localparam logic [5:0]  ERR_SEL         = 6'h03;
  localparam logic [5:0]  ERR_STATION     = 6'h04;
  localparam logic [5:0]  ERR_BAUD        = 6'h05;
  localparam logic [5:0]  ERR_PARITY      = 6'h06;
  localparam logic [5:0]  ERR_P1_BASE     = 6'h0A;
  localparam logic [5:0]  ERR_P2_BASE     = 6'h14;
  localparam logic [5:0]  ERR_NV_WRITE    = 6'h3D;

  // ************************************************************
  // Parameter store geometry
  // ************************************************************
  localparam int unsigned STORE_AW        = 3;
  localparam int unsigned STORE_DW        = 9;

  typedef struct packed {
    logic [7:0] station;
    logic [7:0] baud;
    logic [7:0] parity;
  } spcp_cfg_t;

  typedef struct packed {
    logic                read;
    logic                write;
    logic [AVS_AW-1:0]   address;
    logic [AVS_DW-1:0]   writedata;
  } spcp_avs_req_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_CHECK  = 3'h1,
    ST_DECIDE = 3'h2,
    ST_WRITE  = 3'h3,
    ST_RDADDR = 3'h4,
    ST_RDDATA = 3'h5
  } spcp_state_t;

endpackage

// ==== spcp_store.sv ====
// Persistent parameter store: valid flag plus value per port and parameter
`timescale 1ns/1ps
`default_nettype none
module spcp_store
  import spcp_pkg::*;
(
  input  wire logic                i_mclk,
  input  wire logic                i_resetn,
  input  wire logic                i_we,
  input  wire logic [STORE_AW-1:0] i_addr,
  input  wire logic [STORE_DW-1:0] i_wdata,
  output var  logic [STORE_DW-1:0] o_rdata
);

  logic [STORE_DW-1:0] mem_r [2**STORE_AW];

  // Reset marks every entry as never set
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      for (int i = 0; i < 2**STORE_AW; i++) begin
        mem_r[i] <= '0;
      end
    end else if (i_we) begin
      mem_r[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= mem_r[i_addr];
    end
  end

endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking testbench of the serial port parameter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import spcp_pkg::*;
  typedef struct packed {
    logic       chk;
    logic [7:0] val;
  } spcp_exp_t;
  logic              i_mclk   = 1'b0;
  logic              i_resetn = 1'b0;
  spcp_avs_req_t     i_avs    = '0;
  logic              rd_err   = 1'b0;
  logic              wr_err   = 1'b0;
  spcp_cfg_t         hw_cfg1  = 24'h010000;
  spcp_cfg_t         hw_cfg2  = 24'h020101;
  logic              o_avs_waitrequest;
  logic [AVS_DW-1:0] o_avs_readdata;
  spcp_cfg_t         p1;
  spcp_cfg_t         p2;
  spcp_cfg_t         want;
  logic              o_busy;
  logic [7:0]        rdv;
  logic [47:0]       row;
  spcp_exp_t         mon_e;
  spcp_exp_t         exp_q[$];
  int                miscompares = 0;
  int                n_compared  = 0;
  // Rows: command, select, station, baud, parity, expected status
  logic [47:0]       errs[10] = '{48'hC1_07_01_00_00_81, 48'h61_07_01_00_00_81, 48'h83_07_01_00_00_82,
                                  48'h40_00_00_00_00_82, 48'h81_00_01_00_00_83, 48'h21_00_01_00_00_83,
                                  48'h81_01_00_00_00_84, 48'h82_01_20_00_00_84, 48'h81_02_01_06_00_85,
                                  48'h81_04_01_00_03_86};

  always #12.5 i_mclk = ~i_mclk;

  spcp_ctrl spcp_ctrl_inst (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_avs(i_avs),
    .o_avs_waitrequest(o_avs_waitrequest), .o_avs_readdata(o_avs_readdata), .i_hw_cfg1(hw_cfg1),
    .i_hw_cfg2(hw_cfg2), .i_nv_rd_err(rd_err), .i_nv_wr_err(wr_err), .o_first_serial_port_cfg(p1),
    .o_second_serial_port_cfg(p2), .o_busy(o_busy));

  // ************************************************************
  // Bus tasks and comparisons
  // ************************************************************
  task automatic fail(input string m);
    miscompares++;
    $display("Error at %0t: %s", $time, m);
  endtask

  task automatic chk_cfg(input spcp_cfg_t got, input spcp_cfg_t exp);
    n_compared++;
    if (got !== exp) fail("active configuration mismatch");
  endtask

  // Holds the request until waitrequest is sampled low, releases at that edge
  task automatic bus(input logic rd, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_avs <= '{read: rd, write: !rd, address: a, writedata: {24'h000000, d}};
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fail("bus request never answered");
    rdv = o_avs_readdata[7:0];
    i_avs <= '0;
  endtask

  task automatic rd(input logic [4:0] a, input logic c, input logic [7:0] e);
    exp_q.push_back('{chk: c, val: e});
    bus(1'b1, a, 8'h00);
  endtask

  task automatic setv(input logic [7:0] sel, input spcp_cfg_t v);
    bus(1'b0, OFS_SEL, sel);
    bus(1'b0, OFS_STATION, v.station);
    bus(1'b0, OFS_BAUD, v.baud);
    bus(1'b0, OFS_PARITY, v.parity);
  endtask

  // Start, poll until done, then check status and the self-cleared start bits
  task automatic op(input logic [7:0] cmd, input logic [7:0] stat);
    int n;
    n = 0;
    bus(1'b0, OFS_CMD, cmd);
    @(posedge i_mclk);
    n_compared++;
    if (o_busy !== 1'b1) fail("busy not raised after start");
    do begin
      rd(OFS_STAT, 1'b0, 8'h00);
      n++;
    end while (rdv[7] !== 1'b1 && n < 30);
    n_compared++;
    if (o_busy !== 1'b0) fail("busy still high after completion");
    rd(OFS_STAT, 1'b1, stat);
    rd(OFS_CMD, 1'b1, cmd & 8'h1F);
  endtask

  // Pairs every answered read with the oldest note
  always @(posedge i_mclk) begin
    if (i_avs.read === 1'b1 && o_avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        fail("read with no expectation");
      end else begin
        mon_e = exp_q.pop_front();
        if (mon_e.chk) begin
          n_compared++;
          if (o_avs_readdata !== {24'h000000, mon_e.val}) fail("read data mismatch");
        end
      end
    end
  end

  task automatic close_out;
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_mclk);
    fail("watchdog expired");
    close_out();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'hCBA05E4B));
    @(posedge i_mclk);
    hw_cfg1 <= {8'($urandom_range(31, 1)), 8'($urandom_range(5, 0)), 8'($urandom_range(2, 0))};
    hw_cfg2 <= {8'($urandom_range(31, 1)), 8'($urandom_range(5, 0)), 8'($urandom_range(2, 0))};
    repeat (15) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rd(OFS_STAT, 1'b1, STAT_RST);
    rd(5'h18, 1'b1, 8'h00);
    chk_cfg(p1, hw_cfg1);
    want = {8'($urandom_range(31, 1)), 8'($urandom_range(5, 0)), 8'($urandom_range(2, 0))};
    setv(8'h07, want);
    op(8'h81, 8'hC0);
    chk_cfg(p1, want);
    setv(8'h00, 24'h000000);
    op(8'h41, 8'hC0);
    rd(OFS_STATION, 1'b1, want.station);
    rd(OFS_BAUD, 1'b1, want.baud);
    rd(OFS_PARITY, 1'b1, want.parity);
    setv(8'h02, 24'h000500);
    op(8'h81, 8'hC0);
    want.baud = 8'h05;
    chk_cfg(p1, want);
    setv(8'h07, 24'h1F0402);
    op(8'h82, 8'hC0);
    chk_cfg(p2, 24'h1F0402);
    for (int i = 0; i < 10; i++) begin
      row = errs[i];
      setv(row[39:32], row[31:8]);
      op(row[47:40], row[7:0]);
    end
    chk_cfg(p1, want);
    wr_err <= 1'b1;
    setv(8'h07, 24'h030100);
    op(8'h81, 8'hBD);
    wr_err <= 1'b0;
    chk_cfg(p1, want);
    rd_err <= 1'b1;
    op(8'h42, 8'h94);
    op(8'h41, 8'h8A);
    rd_err <= 1'b0;
    setv(8'h03, 24'h000000);
    op(8'h21, 8'hC0);
    want.station = hw_cfg1.station;
    want.baud = hw_cfg1.baud;
    chk_cfg(p1, want);
    op(8'h41, 8'h8B);
    setv(8'h01, 24'h050000);
    op(8'h81, 8'hC0);
    op(8'h41, 8'h8D);
    setv(8'h07, 24'h000000);
    op(8'h22, 8'hC0);
    chk_cfg(p2, hw_cfg2);
    op(8'h42, 8'h95);
    close_out();
  end
endmodule
`default_nettype wire
